// *** rtl/csc_pkg.sv ***
// Package with register map, field positions and reset values of the capture sequence control block.
package csc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PHASE  = 8'h04;
  localparam logic [7:0] OFS_TSC    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CAP0   = 8'h10;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CONT_ONESHOT_BIT = 0;
  localparam int LIMIT_LO         = 1;
  localparam int REARM_BIT        = 3;
  localparam int RUN_BIT          = 4;
  localparam int SYNC_IN_EN_BIT   = 5;
  localparam int SYNCO_LO         = 6;
  localparam int SW_SYNC_BIT      = 8;
  localparam int MODE_BIT         = 9;
  localparam int POL_BIT          = 10;

  // Stored bits; self-clearing strobes and reserved bits read as zero.
  localparam logic [15:0] CTRL_STORE_MASK = 16'h06F7;
  localparam logic [15:0] CTRL_RESET      = 16'h0006;

  localparam logic [1:0] SYNCO_PASS = 2'h0;
  localparam logic [1:0] SYNCO_PRD  = 2'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CSC_SEQ_RUN,
    CSC_SEQ_STOPPED
  } csc_seq_t;

endpackage

// *** rtl/csc_evt_if.sv ***
// Interface carrying sequencer events between the control top and the capture sequencer.
`timescale 1ns/1ps
interface csc_evt_if;
  logic       cap_evt;    // Qualified capture event.
  logic       oneshot;    // One-shot operation selected.
  logic [1:0] limit;      // Stop or wrap point.
  logic       rearm;      // Rearm strobe.
  logic       cap_mode;   // Capture mode active.
  logic [1:0] seq;        // Event sequence counter.
  logic       load_en;    // Capture load allowed for this event.
  logic       stopped;    // Sequence frozen.
  modport ctl (output cap_evt, oneshot, limit, rearm, cap_mode, input seq, load_en, stopped);
  modport seqr (input cap_evt, oneshot, limit, rearm, cap_mode, output seq, load_en, stopped);
endinterface

// *** rtl/csc_sequencer.sv ***
// Modulo-four capture event sequencer with stop and wrap handling.
`timescale 1ns/1ps
module csc_sequencer (
  input  wire logic aclk,     // Functional clock.
  input  wire logic aresetn,  // Synchronous reset, active low.
  input  wire logic ce,       // Clock enable.
  csc_evt_if.seqr   ev        // Event connection.
);
  logic [1:0]       seq_q;
  logic [1:0]       seq_d;
  csc_pkg::csc_seq_t st_q;
  csc_pkg::csc_seq_t st_d;
  logic             at_limit;
  logic             take;

  assign at_limit   = (seq_q == ev.limit);
  assign take       = ev.cap_evt & ev.cap_mode & (st_q == csc_pkg::CSC_SEQ_RUN);
  assign ev.seq     = seq_q;
  assign ev.load_en = take;
  assign ev.stopped = (st_q == csc_pkg::CSC_SEQ_STOPPED);

  always_comb begin
    seq_d = seq_q;
    st_d  = st_q;
    if (ev.rearm) begin
      seq_d = 2'h0;
      st_d  = csc_pkg::CSC_SEQ_RUN;
    end else if (take) begin
      if (at_limit) begin
        seq_d = 2'h0;
        if (ev.oneshot) begin
          seq_d = seq_q;
          st_d  = csc_pkg::CSC_SEQ_STOPPED;
        end
      end else begin
        seq_d = seq_q + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= 2'h0;
      st_q  <= csc_pkg::CSC_SEQ_RUN;
    end else if (ce) begin
      seq_q <= seq_d;
      st_q  <= st_d;
    end
  end

  a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev.stopped && !ev.rearm |=> ev.stopped && $stable(seq_q)) else $error("stopped sequence moved");
endmodule

// *** rtl/csc_top.sv ***
// Capture sequence control: sync chain, counter run control and capture sequencing over AXI4-Lite.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Software sync loads phase, propagates when select zero.
// - Sync-out select: pass, period match, off.
// - Period match selectable also in capture mode.
// - Sync-in enable gates phase loads.
// - Run bit freezes or frees counter.
// - Rearm clears, unfreezes sequence; reads zero.
// - Rearm works in both operations.
// - Limit code n means event n+1.
// - Continuous capture registers form circular buffer.
// - One-shot limit match freezes sequence, blocks loads; continuous wraps to zero.
// - One-shot stop blocks capture events until rearm.
// - Mode bit: continuous zero, one-shot one.
// - Mode select: capture zero, pulse-width one.
// - Software sync zero write ignored, reads zero.
module csc_top #(
  parameter int CNT_W = 32  // Time-stamp counter width.
) (
  input  wire logic        aclk,           // Functional clock, 20 MHz.
  input  wire logic        aresetn,        // Synchronous reset, active low.
  input  wire logic        ce,             // Clock enable; freezes all state when low.
  input  wire logic        sync_in_pulse,  // Sync-in from upstream module.
  input  wire logic        cap_pin,        // Capture input pin.
  input  wire logic        period_match,   // Period-match event, same clock domain.
  output logic             sync_out,       // Sync-out to downstream module.
  output logic             cap_event,      // Capture interrupt event pulse.
  output logic             capture_mode,   // High while in capture mode.
  input  wire logic [7:0]  s_axi_awaddr,   // Write address.
  input  wire logic        s_axi_awvalid,  // Write address valid.
  output logic             s_axi_awready,  // Write address ready.
  input  wire logic [31:0] s_axi_wdata,    // Write data.
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
  input  wire logic        s_axi_wvalid,   // Write data valid.
  output logic             s_axi_wready,   // Write data ready.
  output logic [1:0]       s_axi_bresp,    // Write response.
  output logic             s_axi_bvalid,   // Write response valid.
  input  wire logic        s_axi_bready,   // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,   // Read address.
  input  wire logic        s_axi_arvalid,  // Read address valid.
  output logic             s_axi_arready,  // Read address ready.
  output logic [31:0]      s_axi_rdata,    // Read data.
  output logic [1:0]       s_axi_rresp,    // Read response.
  output logic             s_axi_rvalid,   // Read data valid.
  input  wire logic        s_axi_rready    // Read data ready.
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0]      ctrl_q;
  logic [CNT_W-1:0] phase_q;
  logic [CNT_W-1:0] tsc_q;
  logic [CNT_W-1:0] tsc_d;
  logic [CNT_W-1:0] cap_q [4];
  logic [2:0]       syn_in_q;
  logic [2:0]       pin_q;
  logic             sw_sync_q;
  logic             rearm_q;
  logic             sync_out_q;
  logic             cap_event_q;
  logic             capture_mode_q;
  csc_evt_if        ev ();

  csc_sequencer u_seq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .ev      (ev)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire       oneshot   = ctrl_q[csc_pkg::CONT_ONESHOT_BIT];
  wire [1:0] limit     = ctrl_q[csc_pkg::LIMIT_LO +: 2];
  wire       run       = ctrl_q[csc_pkg::RUN_BIT];
  wire       sync_in_en   = ctrl_q[csc_pkg::SYNC_IN_EN_BIT];
  wire [1:0] sync_out_sel = ctrl_q[csc_pkg::SYNCO_LO +: 2];
  wire       pwm_mode     = ctrl_q[csc_pkg::MODE_BIT];
  wire       cap_mode     = ~pwm_mode;
  // Rising edge of the synchronised inputs; stage 0 is read only by stage 1.
  wire       sync_rise = syn_in_q[1] & ~syn_in_q[2];
  wire       pin_rise  = pin_q[1] & ~pin_q[2];
  wire       load_evt  = sync_in_en & (sync_rise | sw_sync_q);

  assign ev.cap_evt  = pin_rise;
  assign ev.oneshot  = oneshot;
  assign ev.limit    = limit;
  assign ev.rearm    = rearm_q;
  assign ev.cap_mode = cap_mode;

  // ----------------------------------------------------------------
  // Sync-out and counter
  // ----------------------------------------------------------------
  wire sync_out_d = (sync_out_sel == csc_pkg::SYNCO_PASS) ? (sync_rise | sw_sync_q) :
                    (sync_out_sel == csc_pkg::SYNCO_PRD)  ? period_match : 1'b0;

  always_comb begin
    tsc_d = tsc_q;
    if (load_evt) begin
      tsc_d = phase_q;
    end else if (pwm_mode && period_match) begin
      tsc_d = '0;
    end else if (run) begin
      tsc_d = tsc_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [1:0]  wstrb_lo_q;
  logic        w_have_q;
  wire         wr_go  = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire         wr_ok  = (awaddr_q == csc_pkg::OFS_CTRL) | (awaddr_q == csc_pkg::OFS_PHASE);
  wire         wr_ctl = wr_go & (awaddr_q == csc_pkg::OFS_CTRL);
  wire         wr_phs = wr_go & (awaddr_q == csc_pkg::OFS_PHASE);
  wire [15:0]  bmask  = {{8{wstrb_lo_q[1]}}, {8{wstrb_lo_q[0]}}};
  wire [15:0]  ctl_wv = (ctrl_q & ~bmask) | (wdata_q[15:0] & bmask);
  wire         ar_go  = s_axi_arvalid & s_axi_arready;

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      csc_pkg::OFS_CTRL:   r = {16'h0000, ctrl_q & csc_pkg::CTRL_STORE_MASK};
      csc_pkg::OFS_PHASE:  r = 32'(phase_q);
      csc_pkg::OFS_TSC:    r = 32'(tsc_q);
      csc_pkg::OFS_STATUS: r = {27'h000_0000, ev.stopped, ev.seq, cap_mode, oneshot};
      8'h10:               r = 32'(cap_q[0]);
      8'h14:               r = 32'(cap_q[1]);
      8'h18:               r = 32'(cap_q[2]);
      8'h1C:               r = 32'(cap_q[3]);
      default:             r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic rd_ok(input logic [7:0] a);
    return (a <= 8'h1C) && (a[1:0] == 2'b00);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_lo_q    <= 2'b00;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= csc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= csc_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q   <= 1'b1;
        wdata_q    <= s_axi_wdata;
        wstrb_lo_q <= s_axi_wstrb[1:0];
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? csc_pkg::RESP_OKAY : csc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (ar_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux(s_axi_araddr);
        s_axi_rresp  <= rd_ok(s_axi_araddr) ? csc_pkg::RESP_OKAY : csc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= csc_pkg::CTRL_RESET;
      phase_q  <= '0;
      sw_sync_q <= 1'b0;
      rearm_q  <= 1'b0;
    end else if (ce) begin
      // Strobes last one cycle; a written zero leaves them low.
      sw_sync_q <= wr_ctl & wstrb_lo_q[1] & wdata_q[csc_pkg::SW_SYNC_BIT];
      rearm_q  <= wr_ctl & wstrb_lo_q[0] & wdata_q[csc_pkg::REARM_BIT];
      if (wr_ctl) begin
        ctrl_q <= ctl_wv & csc_pkg::CTRL_STORE_MASK;
      end
      if (wr_phs) begin
        phase_q <= wdata_q[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syn_in_q       <= 3'b000;
      pin_q          <= 3'b000;
      tsc_q          <= '0;
      sync_out_q     <= 1'b0;
      cap_event_q    <= 1'b0;
      capture_mode_q <= 1'b1;
    end else if (ce) begin
      syn_in_q       <= {syn_in_q[1:0], sync_in_pulse};
      pin_q          <= {pin_q[1:0], cap_pin};
      tsc_q          <= tsc_d;
      sync_out_q     <= sync_out_d;
      cap_event_q    <= ev.load_en;
      capture_mode_q <= cap_mode;
    end
  end

  // Capture registers: only the slot chosen by the sequencer is written.
  for (genvar i = 0; i < 4; i++) begin : g_cap
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cap_q[i] <= '0;
      end else if (ce && ev.load_en && ev.seq == 2'(i)) begin
        cap_q[i] <= tsc_q;
      end
    end
  end

  assign sync_out     = sync_out_q;
  assign cap_event    = cap_event_q;
  assign capture_mode = capture_mode_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_sw_sync_wr;
    ce && wr_ctl && wstrb_lo_q[1] && wdata_q[csc_pkg::SW_SYNC_BIT];
  endsequence

  a_sw_sync_load: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sw_sync_q && sync_in_en |=> tsc_q == $past(phase_q)) else $error("software sync did not load phase");
  a_sw_sync_out: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sw_sync_wr ##1 (ce && sync_out_sel == 2'h0) |=> sync_out) else $error("software sync not propagated");
  a_synco_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sync_out_sel[1] |=> !sync_out) else $error("sync out not disabled");
  a_synco_prd: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sync_out_sel == 2'h1 |=> sync_out == $past(period_match)) else $error("period match not routed");
  a_sync_in_pulse_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !sync_in_en && !pwm_mode && !run |=> $stable(tsc_q)) else $error("counter loaded while sync disabled");
  a_run_count: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && run && !load_evt && !pwm_mode |=> tsc_q == $past(tsc_q) + 1'b1) else $error("counter not counting");
  a_rearm_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rearm_q |=> ev.seq == 2'h0 && !ev.stopped) else $error("rearm did not clear sequence");
  a_ctrl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ar_go && s_axi_araddr == csc_pkg::OFS_CTRL |=> !s_axi_rdata[8] && !s_axi_rdata[3])
    else $error("strobe bit read as one");
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev.load_en && !oneshot && ev.seq == limit && !rearm_q |=> ev.seq == 2'h0) else $error("no wrap");
  a_oneshot_block: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && ev.stopped && !rearm_q |=> !cap_event) else $error("event passed after stop");

endmodule

// *** bench/csc_neighbour.sv ***
// Model of the neighbouring capture modules on the sync chain and of the capture source.
`timescale 1ns/1ps
module csc_neighbour (
  input  wire logic aclk,           // Functional clock.
  input  wire logic sync_out,       // Sync-out of the block, seen downstream.
  output logic      sync_in_pulse,  // Sync-in from the upstream neighbour.
  output logic      period_match,   // Period-match event.
  output logic      cap_pin         // Capture input.
);
  int   n_sync_seen = 0;
  logic sync_out_q  = 1'b0;

  initial begin
    sync_in_pulse = 1'b0;
    period_match  = 1'b0;
    cap_pin       = 1'b0;
  end

  // Rising edges are counted, so a stretched pulse still counts once.
  always @(posedge aclk) begin
    sync_out_q <= sync_out;
    if (sync_out === 1'b1 && sync_out_q !== 1'b1) n_sync_seen <= n_sync_seen + 1;
  end

  // Levels are held four cycles so that the block's two-stage synchroniser sees them.
  task automatic send_sync();
    sync_in_pulse <= 1'b1;
    repeat (4) @(posedge aclk);
    sync_in_pulse <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic send_cap();
    cap_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    cap_pin <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic send_prd();
    period_match <= 1'b1;
    @(posedge aclk);
    period_match <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
endmodule

// *** bench/test_capture_sequence_sync_control.sv ***
// Self-checking testbench for the capture sequence control block.
`timescale 1ns/1ps
module test_capture_sequence_sync_control;
  logic        aclk, aresetn, ce, sync_in_pulse, period_match, cap_pin;
  logic        sync_out, cap_event, capture_mode;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c1;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_cap = 0;
  int          n_cyc = 0;
  int          b;

  csc_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .sync_in_pulse(sync_in_pulse), .cap_pin(cap_pin),
    .period_match(period_match), .sync_out(sync_out), .cap_event(cap_event), .capture_mode(capture_mode),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  csc_neighbour nb_u (
    .aclk(aclk), .sync_out(sync_out), .sync_in_pulse(sync_in_pulse),
    .period_match(period_match), .cap_pin(cap_pin)
  );

  always #25 aclk = ~aclk;

  // The ceiling is some forty times the length of the planned sequence.
  always @(posedge aclk) begin
    n_cyc <= n_cyc + 1;
    if (cap_event === 1'b1) n_cap <= n_cap + 1;
    if (n_cyc == 20000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: response %h, expected %h", $time, got, exp);
    end
  endtask

  // Bready and rready stay high, so the answer is taken at the edge it is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk_resp(s_axi_bresp, er);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, rd, rs);
    chk_val(rd, e);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    {s_axi_bready, s_axi_rready} = 2'b11;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_val(32'(capture_mode), 32'h0000_0001);
    rchk(csc_pkg::OFS_CTRL, 32'h0000_0006);
    rchk(csc_pkg::OFS_STATUS, 32'h0000_0002);
    rd_reg(8'h20, rd, rs);
    chk_resp(rs, csc_pkg::RESP_SLVERR);
    wr(8'h20, 32'h0000_0001, csc_pkg::RESP_SLVERR);
    // Forced load with the counter frozen, then with sync-in disabled.
    wr(csc_pkg::OFS_PHASE, 32'h1234_0000, csc_pkg::RESP_OKAY);
    b = nb_u.n_sync_seen;
    wr(csc_pkg::OFS_CTRL, 32'h0000_0126, csc_pkg::RESP_OKAY);
    rchk(csc_pkg::OFS_TSC, 32'h1234_0000);
    chk_val(32'(nb_u.n_sync_seen - b), 32'h0000_0001);
    rchk(csc_pkg::OFS_CTRL, 32'h0000_0026);
    wr(csc_pkg::OFS_PHASE, 32'h5555_0000, csc_pkg::RESP_OKAY);
    wr(csc_pkg::OFS_CTRL, 32'h0000_0106, csc_pkg::RESP_OKAY);
    rchk(csc_pkg::OFS_TSC, 32'h1234_0000);
    wr(csc_pkg::OFS_CTRL, 32'h0000_0016, csc_pkg::RESP_OKAY);
    rd_reg(csc_pkg::OFS_TSC, c1, rs);
    rd_reg(csc_pkg::OFS_TSC, rd, rs);
    chk_val(32'(rd > c1), 32'h0000_0001);
    for (int s = 0; s < 4; s++) begin
      wr(csc_pkg::OFS_CTRL, 32'h0000_0006 | (32'(s) << 6), csc_pkg::RESP_OKAY);
      b = nb_u.n_sync_seen;
      nb_u.send_sync();
      chk_val(32'(nb_u.n_sync_seen - b), 32'(s == 0));
      b = nb_u.n_sync_seen;
      nb_u.send_prd();
      chk_val(32'(nb_u.n_sync_seen - b), 32'(s == 1));
    end
    // One-shot stop at every limit code; five events overrun each limit.
    for (int l = 0; l < 4; l++) begin
      wr(csc_pkg::OFS_CTRL, 32'h0000_0019 | (32'(l) << 1), csc_pkg::RESP_OKAY);
      b = n_cap;
      repeat (5) nb_u.send_cap();
      chk_val(32'(n_cap - b), 32'(l + 1));
      rchk(csc_pkg::OFS_STATUS, 32'h0000_0013 | (32'(l) << 2));
    end
    wr(csc_pkg::OFS_CTRL, 32'h0000_000F, csc_pkg::RESP_OKAY);
    rchk(csc_pkg::OFS_STATUS, 32'h0000_0003);
    rchk(csc_pkg::OFS_CTRL, 32'h0000_0007);
    // Continuous operation wrapping after the second slot.
    wr(csc_pkg::OFS_CTRL, 32'h0000_001A, csc_pkg::RESP_OKAY);
    b = n_cap;
    nb_u.send_cap();
    rd_reg(csc_pkg::OFS_CAP0, c1, rs);
    repeat (2) nb_u.send_cap();
    rd_reg(csc_pkg::OFS_CAP0, rd, rs);
    chk_val(32'(n_cap - b), 32'h0000_0003);
    chk_val(32'(rd > c1), 32'h0000_0001);
    rchk(csc_pkg::OFS_STATUS, 32'h0000_0006);
    wr(csc_pkg::OFS_CTRL, 32'h0000_001A, csc_pkg::RESP_OKAY);
    rchk(csc_pkg::OFS_STATUS, 32'h0000_0002);
    // Pulse-width mode must stop capture loads.
    wr(csc_pkg::OFS_CTRL, 32'h0000_0216, csc_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk_val(32'(capture_mode), 32'h0000_0000);
    b = n_cap;
    nb_u.send_cap();
    chk_val(32'(n_cap - b), 32'h0000_0000);
    give_verdict();
  end
endmodule
